//--- oore_display_model.sv
// Analog output and front-panel display model for the output scaler
`timescale 1ns/100ps
module oore_display_model import oore_pkg::*; (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire oore_res_s [2:0] chRes,
    input wire logic signed [OW-1:0] firstOut,
    input wire logic signed [OW-1:0] secondOut,
    output logic rangeErr
);
    logic bad;
    // A real converter clips silently, so an excess is flagged here instead
    always_comb
    begin
        bad = (firstOut > FS_MV) || (firstOut < -FS_MV);
        bad = bad || (secondOut > FS_MV) || (secondOut < -FS_MV);
        for (int i = 0; i < 3; i++)
        begin
            bad = bad || (chRes[i].analog > FS_MV) || (chRes[i].analog < -FS_MV);
            bad = bad || (chRes[i].bar !== chRes[i].analog);
        end
    end
    // Sticky, so a one-cycle excursion is not lost
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            rangeErr <= 1'b0;
        else if (bad)
            rangeErr <= 1'b1;
    end
endmodule

//--- oore_divider.sv
// Iterative signed divider, one quotient bit per clock
`timescale 1ns/100ps
module oore_divider import oore_pkg::*; #(
    parameter int W = NUMW
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic signed [W-1:0] num,
    input wire logic [W-1:0] den,
    output logic done,
    output logic signed [W-1:0] quot
);
    localparam int CW = $clog2(W + 1);
    logic [W-1:0] remReg;
    logic [W-1:0] shReg;
    logic [W-1:0] denReg;
    logic [CW-1:0] cntReg;
    logic negReg;
    logic [W+1:0] diff;

    assign diff = {1'b0, remReg, shReg[W-1]} - {2'b00, denReg};
    assign quot = negReg ? -$signed(shReg) : $signed(shReg);

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            remReg <= '0;
            shReg <= '0;
            denReg <= '0;
            cntReg <= '0;
            negReg <= 1'b0;
        end
        else if (start)
        begin
            shReg <= num[W-1] ? W'(-num) : W'(num);
            negReg <= num[W-1];
            denReg <= den;
            remReg <= '0;
            cntReg <= CW'(W);
        end
        else if (cntReg != '0)
        begin
            shReg <= {shReg[W-2:0], ~diff[W+1]};
            remReg <= diff[W+1] ? {remReg[W-2:0], shReg[W-1]} : diff[W-1:0];
            cntReg <= cntReg - CW'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            done <= 1'b0;
        else
            done <= !start && (cntReg == CW'(1));
    end
endmodule

//--- oore_output_scaler.sv
// Output offset, ratio and expand datapath with phase scaling and indicators
//
// Notes on behaviour
// - Phase kept within half turn; 18 deg/V
// - Phase bar and readout ignore sensitivity
// - Offset is percent of sensitivity, max 999
// - Ratio lamp lit whenever any ratio enabled
// - Output = (value/(sens/ratio) - offset)*expand*10V
// - Expand multiplies the offset-removed value
// - Expand is 1, 10, 100; output within 10V
// - Aux3 ratios X and Y, aux4 ratios R
// - Magnitude has its own offset, ratio, expand
// - Phase has no offset, ratio or expand
// - Displays and remote values include offset, ratio
// - Offset and ratio marks shown when active
// - Readout not expanded, shows value minus offset
// - Expand mark shown when factor not one
// - Bar graph follows the expanded analog output
// - Chart values carry offset but no expand
// - Gain rises with smaller range, stops 10mV
// - Value equal to sensitivity gives 10V
// - Overload flagged; outputs pinned, chart not
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/100ps
module oore_output_scaler import oore_pkg::*; (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    input wire logic sampleValid,
    input wire logic signed [VALW-1:0] inX,
    input wire logic signed [VALW-1:0] inY,
    input wire logic signed [VALW-1:0] inR,
    input wire logic signed [OW:0] inPhase,
    input wire logic signed [AUXW-1:0] aux3,
    input wire logic signed [AUXW-1:0] aux4,
    output oore_res_s [2:0] chRes,
    output logic [2:0] offInd,
    output logic [2:0] ratInd,
    output logic [2:0] expInd,
    output logic ratioLed,
    output logic signed [OW-1:0] firstOut,
    output logic signed [OW-1:0] secondOut,
    output logic signed [OW-1:0] phaseBar,
    output logic signed [OW-1:0] phaseReadout,
    output logic [RANGEW-1:0] gainCode,
    output logic busy
);
    oore_cfg_s [2:0] cfgReg;
    logic [SENSW-1:0] sensReg;
    logic firstSelReg;
    logic secondSelReg;
    logic [RANGEW-1:0] rangeReg;
    oore_state_e state;
    logic [1:0] chIdx;
    logic signed [VALW-1:0] valReg [3];
    logic signed [AUXW-1:0] aux3Reg;
    logic signed [AUXW-1:0] aux4Reg;
    logic signed [QW-1:0] qReg;
    logic signed [AUXW-1:0] ratioUse;
    logic signed [NUMW-1:0] numVal;
    logic [NUMW-1:0] denVal;
    logic divDone;
    logic signed [NUMW-1:0] divQuot;
    oore_res_s scaleRes;
    logic [31:0] rdMux;

    ////////////////////////////////////////////////////////////////////////
    function automatic oore_cfg_s cfgFromWord(input logic [31:0] w);
        oore_cfg_s c;
        logic signed [PCTW-1:0] p;
        p = w[CFG_OFF_LSB +: PCTW];
        if (p > PCT_MAX) c.offPct = PCT_MAX;
        else if (p < -PCT_MAX) c.offPct = -PCT_MAX;
        else c.offPct = p;
        c.ratioEn = w[CFG_RAT_BIT];
        // Unused code falls back to unity rather than an odd factor
        c.expCode = (w[CFG_EXP_LSB +: 2] == 2'h3) ? 2'h0 : w[CFG_EXP_LSB +: 2];
        return c;
    endfunction
    function automatic logic [31:0] cfgToWord(input oore_cfg_s c);
        return {17'h0, c.expCode, c.ratioEn, 1'b0, c.offPct};
    endfunction
    function automatic logic signed [OW-1:0] wrapPhase(input logic signed [OW:0] p);
        logic signed [OW:0] q;
        q = p;
        if (p > PH_HALF) q = p - PH_TURN;
        else if (p < -PH_HALF) q = p + PH_TURN;
        return q[OW-1:0];
    endfunction
    function automatic logic signed [OW-1:0] phaseToMv(input logic signed [OW-1:0] p);
        logic signed [QW-1:0] t;
        t = (QW'(p) * PH_MV_NUM) / PH_MV_DEN;
        return t[OW-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cfgReg <= '0;
            sensReg <= SENS_RST;
            firstSelReg <= 1'b0;
            secondSelReg <= 1'b0;
            rangeReg <= RANGE_RST;
        end
        else if (regWr)
        begin
            if (regAddr == ADDR_CFG_X)
                cfgReg[0] <= cfgFromWord(regWrData);
            else if (regAddr == ADDR_CFG_Y)
                cfgReg[1] <= cfgFromWord(regWrData);
            else if (regAddr == ADDR_CFG_R)
                cfgReg[2] <= cfgFromWord(regWrData);
            else if (regAddr == ADDR_SENS)
                // Zero would divide by zero; offsets stay in percent
                sensReg <= (regWrData[SENSW-1:0] == '0) ? SENSW'(1) : regWrData[SENSW-1:0];
            else if (regAddr == ADDR_MISC)
            begin
                firstSelReg <= regWrData[MISC_FIRST_BIT];
                secondSelReg <= regWrData[MISC_SECOND_BIT];
                rangeReg <= regWrData[MISC_RANGE_LSB +: RANGEW];
            end
        end
    end

    // Register reads: data valid only in the cycle after the strobe
    always_comb
    begin
        rdMux = 32'h0;
        if (regAddr == ADDR_CFG_X)
            rdMux = cfgToWord(cfgReg[0]);
        else if (regAddr == ADDR_CFG_Y)
            rdMux = cfgToWord(cfgReg[1]);
        else if (regAddr == ADDR_CFG_R)
            rdMux = cfgToWord(cfgReg[2]);
        else if (regAddr == ADDR_SENS)
            rdMux = 32'(sensReg);
        else if (regAddr == ADDR_MISC)
            rdMux = {27'h0, rangeReg, secondSelReg, firstSelReg};
        else if (regAddr == ADDR_STAT)
            rdMux = {28'h0, busy, chRes[2].ovl, chRes[1].ovl, chRes[0].ovl};
        else if (regAddr == ADDR_RD_X)
            rdMux = chRes[0].chart[31:0];
        else if (regAddr == ADDR_RD_Y)
            rdMux = chRes[1].chart[31:0];
        else if (regAddr == ADDR_RD_R)
            rdMux = chRes[2].chart[31:0];
        else if (regAddr == ADDR_RD_PH)
            rdMux = 32'(phaseReadout);
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            regRdData <= 32'h0;
        else
            regRdData <= regRd ? rdMux : 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel sequencer: X, Y then R share one divider
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= ST_IDLE;
            chIdx <= 2'h0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                    if (sampleValid)
                    begin
                        chIdx <= 2'h0;
                        state <= ST_LOAD;
                    end
                ST_LOAD:
                    state <= ST_DIV;
                ST_DIV:
                    if (divDone)
                        state <= ST_STORE;
                ST_STORE:
                    if (chIdx == 2'h2)
                        state <= ST_IDLE;
                    else
                    begin
                        chIdx <= chIdx + 2'h1;
                        state <= ST_LOAD;
                    end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Samples arriving mid-sequence are dropped, not queued
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            valReg <= '{default: '0};
            aux3Reg <= ONE_VOLT_MV;
            aux4Reg <= ONE_VOLT_MV;
        end
        else if (state == ST_IDLE && sampleValid)
        begin
            valReg[0] <= inX;
            valReg[1] <= inY;
            valReg[2] <= inR;
            aux3Reg <= aux3;
            aux4Reg <= aux4;
        end
    end
    always_comb
    begin
        if (!cfgReg[chIdx].ratioEn)
            ratioUse = ONE_VOLT_MV;
        else if (chIdx == 2'h2)
            ratioUse = aux4Reg;
        else
            ratioUse = aux3Reg;
        // value * (ratio / 1 V) * 10 V / sensitivity, in mV
        numVal = NUMW'(valReg[chIdx]) * NUMW'(ratioUse) * NUMW'(FS_MV);
        denVal = NUMW'(sensReg) * NUMW'(ONE_VOLT_MV);
    end
    oore_divider #(.W(NUMW)) uDiv (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .start(state == ST_LOAD),
        .num(numVal),
        .den(denVal),
        .done(divDone),
        .quot(divQuot)
    );
    // Saturate far beyond full scale so later math cannot wrap
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            qReg <= '0;
        else if (state == ST_DIV && divDone)
        begin
            if (divQuot > QMAX) qReg <= QMAX[QW-1:0];
            else if (divQuot < -QMAX) qReg <= -QMAX[QW-1:0];
            else qReg <= divQuot[QW-1:0];
        end
    end
    oore_scale uScale (
        .quot(qReg),
        .cfg(cfgReg[chIdx]),
        .res(scaleRes)
    );
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            chRes <= '0;
        else if (state == ST_STORE)
            chRes[chIdx] <= scaleRes;
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase path: no offset, ratio or expand
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            phaseBar <= '0;
            phaseReadout <= '0;
        end
        else if (state == ST_IDLE && sampleValid)
        begin
            phaseBar <= wrapPhase(inPhase);
            phaseReadout <= wrapPhase(inPhase);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            firstOut <= '0;
            secondOut <= '0;
        end
        else
        begin
            firstOut <= firstSelReg ? chRes[2].analog : chRes[0].analog;
            secondOut <= secondSelReg ? phaseToMv(phaseReadout) : chRes[1].analog;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Indicators and status
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            offInd <= 3'h0;
            ratInd <= 3'h0;
            expInd <= 3'h0;
            ratioLed <= 1'b0;
            gainCode <= RANGE_RST;
            busy <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                offInd[i] <= cfgReg[i].offPct != '0;
                expInd[i] <= expFactor(cfgReg[i].expCode) != 8'h01;
            end
            ratInd[0] <= cfgReg[0].ratioEn && (aux3Reg != ONE_VOLT_MV);
            ratInd[1] <= cfgReg[1].ratioEn && (aux3Reg != ONE_VOLT_MV);
            ratInd[2] <= cfgReg[2].ratioEn && (aux4Reg != ONE_VOLT_MV);
            ratioLed <= cfgReg[0].ratioEn || cfgReg[1].ratioEn || cfgReg[2].ratioEn;
            // Beyond the 10 mV setting more gain buys no noise benefit
            gainCode <= (rangeReg > RANGE_10MV) ? RANGE_10MV : rangeReg;
            busy <= state != ST_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cbMain @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    sequence sqChanLoad;
        state == ST_LOAD && chIdx == 2'h0;
    endsequence
    sequence sqChanStore;
        state == ST_STORE && chIdx == 2'h0;
    endsequence
    AST_DIV_LATENCY: assert property (sqChanLoad |-> ##[56:60] sqChanStore)
        else $error("Channel result not ready in time");
    AST_ANALOG_LIMIT: assert property (chRes[0].analog <= FS_MV && chRes[0].analog >= -FS_MV
        && chRes[2].analog <= FS_MV && chRes[2].analog >= -FS_MV)
        else $error("Analog output beyond full scale");
    AST_OVL_PINNED: assert property (chRes[0].ovl |-> (chRes[0].bar == FS_MV
        || chRes[0].bar == -FS_MV))
        else $error("Overload without pinned bar");
    AST_NEG_SAT: assert property ((chRes[1].ovl && chRes[1].chart < 0)
        |-> chRes[1].analog == -FS_MV)
        else $error("Negative overload not at minus full scale");
    AST_READOUT_NOEXP: assert property (chRes[2].readout
        == clampFs(48'(chRes[2].chart)))
        else $error("Readout differs from clamped offset value");
    AST_PHASE_RANGE: assert property (phaseReadout <= 16'sh4650
        && phaseReadout >= -16'sh4650)
        else $error("Phase outside half turn");
    AST_PHASE_VOLT: assert property ($past(secondSelReg) && $stable(phaseReadout)
        |-> secondOut == phaseToMv(phaseReadout))
        else $error("Second output phase scale wrong");
    AST_RATIO_LED: assert property ((cfgReg[0].ratioEn || cfgReg[2].ratioEn)
        |=> ratioLed)
        else $error("Ratio lamp dark while ratio enabled");
    AST_EXP_IND: assert property (cfgReg[1].expCode == 2'h0 |=> !expInd[1])
        else $error("Expand mark with unity factor");
    AST_OFFSET_LIMIT: assert property (cfgReg[0].offPct <= PCT_MAX
        && cfgReg[0].offPct >= -PCT_MAX)
        else $error("Stored offset beyond 999 percent");
    AST_GAIN_CAP: assert property (gainCode <= RANGE_10MV)
        else $error("Gain beyond 10 mV setting");
endmodule

//--- oore_pkg.sv
// Constants, types and shared arithmetic for the output offset/ratio/expand block
package oore_pkg;
    localparam int VALW = 24;
    localparam int AUXW = 16;
    localparam int SENSW = 24;
    localparam int NUMW = 56;
    localparam int QW = 32;
    localparam int CHW = 34;
    localparam int OW = 16;
    localparam int PCTW = 11;
    localparam int RANGEW = 3;
    // Register byte offsets
    localparam logic [7:0] ADDR_CFG_X = 8'h00;
    localparam logic [7:0] ADDR_CFG_Y = 8'h04;
    localparam logic [7:0] ADDR_CFG_R = 8'h08;
    localparam logic [7:0] ADDR_SENS = 8'h0c;
    localparam logic [7:0] ADDR_MISC = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;
    localparam logic [7:0] ADDR_RD_X = 8'h18;
    localparam logic [7:0] ADDR_RD_Y = 8'h1c;
    localparam logic [7:0] ADDR_RD_R = 8'h20;
    localparam logic [7:0] ADDR_RD_PH = 8'h24;
    // Field positions
    localparam int CFG_OFF_LSB = 0;
    localparam int CFG_RAT_BIT = 12;
    localparam int CFG_EXP_LSB = 13;
    localparam int MISC_FIRST_BIT = 0;
    localparam int MISC_SECOND_BIT = 1;
    localparam int MISC_RANGE_LSB = 2;
    // Reset values; RANGE_10MV is the gain cap
    localparam logic [SENSW-1:0] SENS_RST = 24'h0003e8;
    localparam logic [RANGEW-1:0] RANGE_RST = 3'h0;
    localparam logic [RANGEW-1:0] RANGE_10MV = 3'h4;
    // Scale: full scale is 10000 mV, ratio reference is 1.000 V
    localparam logic signed [OW-1:0] FS_MV = 16'sh2710;
    localparam logic signed [AUXW-1:0] ONE_VOLT_MV = 16'sh03e8;
    localparam logic signed [PCTW-1:0] PCT_MAX = 11'sh3e7;
    localparam logic signed [QW-1:0] PCT_COUNTS = 32'sh00000064;
    localparam logic signed [NUMW-1:0] QMAX = 56'sh00000040000000;
    // Phase in hundredths of a degree; 1800 per volt
    localparam logic signed [OW:0] PH_HALF = 17'sh04650;
    localparam logic signed [OW:0] PH_TURN = 17'sh08ca0;
    localparam logic signed [QW-1:0] PH_MV_NUM = 32'sh00000005;
    localparam logic signed [QW-1:0] PH_MV_DEN = 32'sh00000009;

    typedef enum {ST_IDLE, ST_LOAD, ST_DIV, ST_STORE} oore_state_e;

    typedef struct packed {
        logic signed [PCTW-1:0] offPct;
        logic ratioEn;
        logic [1:0] expCode;
    } oore_cfg_s;

    typedef struct packed {
        logic signed [OW-1:0] analog;
        logic signed [OW-1:0] bar;
        logic signed [OW-1:0] readout;
        logic signed [CHW-1:0] chart;
        logic ovl;
    } oore_res_s;

    function automatic logic [7:0] expFactor(input logic [1:0] code);
        if (code == 2'h1) return 8'h0a;
        else if (code == 2'h2) return 8'h64;
        else return 8'h01;
    endfunction

    function automatic logic signed [OW-1:0] clampFs(input logic signed [47:0] v);
        if (v > 48'(FS_MV)) return FS_MV;
        else if (v < -48'(FS_MV)) return -FS_MV;
        else return v[OW-1:0];
    endfunction
endpackage

//--- oore_scale.sv
// Offset removal, expand and full-scale clamping for one channel
`timescale 1ns/100ps
module oore_scale import oore_pkg::*; (
    input wire logic signed [QW-1:0] quot,
    input wire oore_cfg_s cfg,
    output oore_res_s res
);
    logic signed [CHW-1:0] delta;
    logic signed [47:0] expanded;

    always_comb
    begin
        delta = CHW'(quot) - CHW'(cfg.offPct * PCT_COUNTS);
        // Expand acts on the value with its offset already removed
        expanded = 48'(delta) * $signed({40'h0, expFactor(cfg.expCode)});
        res.chart = delta;
        res.readout = clampFs(48'(delta));
        res.analog = clampFs(expanded);
        res.bar = res.analog;
        res.ovl = (expanded > 48'(FS_MV)) || (expanded < -48'(FS_MV));
    end
endmodule

//--- output_offset_ratio_expand_tb.sv
// Self-checking testbench for the output offset, ratio and expand block
`timescale 1ns/100ps
module output_offset_ratio_expand_tb import oore_pkg::*;;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdData;
    logic sampleValid = 1'b0;
    logic signed [VALW-1:0] inX = '0, inY = '0, inR = '0;
    logic signed [OW:0] inPhase = '0;
    logic signed [AUXW-1:0] aux3 = 16'sh03e8, aux4 = 16'sh03e8;
    oore_res_s [2:0] chRes;
    logic [2:0] offInd, ratInd, expInd;
    logic ratioLed, busy, rangeErr;
    logic signed [OW-1:0] firstOut, secondOut, phaseBar, phaseReadout;
    logic [RANGEW-1:0] gainCode;
    int fail_count = 0;
    int compares = 0;

    always #10 sys_clk = ~sys_clk;

    oore_output_scaler dut (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .sampleValid(sampleValid), .inX(inX), .inY(inY), .inR(inR), .inPhase(inPhase),
        .aux3(aux3), .aux4(aux4), .chRes(chRes), .offInd(offInd), .ratInd(ratInd),
        .expInd(expInd), .ratioLed(ratioLed), .firstOut(firstOut), .secondOut(secondOut),
        .phaseBar(phaseBar), .phaseReadout(phaseReadout), .gainCode(gainCode), .busy(busy));

    oore_display_model model (.sys_clk(sys_clk), .rstn(rstn), .chRes(chRes),
        .firstOut(firstOut), .secondOut(secondOut), .rangeErr(rangeErr));

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic signed [63:0] got, input logic signed [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        chk(regRdData, exp);
    endtask

    task automatic sample(input int x, input int y, input int r, input int ph);
        int n;
        @(posedge sys_clk);
        sampleValid <= 1'b1;
        inX <= VALW'(x);
        inY <= VALW'(y);
        inR <= VALW'(r);
        inPhase <= 17'(ph);
        @(posedge sys_clk);
        sampleValid <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(busy, 64'(1'b1));
        n = 0;
        while (busy !== 1'b0 && n < 400)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n == 400)
        begin
            fail_count++;
            report_and_stop();
        end
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    // Expected channel fields: analog, bar, readout, chart, overload
    task automatic chkCh(input int i, input int an, input int ro, input int ch, input logic ov);
        chk(chRes[i].analog, 64'(an));
        chk(chRes[i].bar, 64'(an));
        chk(chRes[i].readout, 64'(ro));
        chk(chRes[i].chart, 64'(ch));
        chk(chRes[i].ovl, 64'(ov));
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rd(ADDR_SENS, 32'h000003e8);
        rd(ADDR_CFG_X, 32'h0);
        rd(ADDR_MISC, 32'h0);
        wr(8'h30, 32'h0000ffff);
        rd(8'h30, 32'h0);
        // Plain scaling; exactly full scale is not an overload
        sample(500, -300, 1000, 0);
        chkCh(0, 5000, 5000, 5000, 1'b0);
        chkCh(1, -3000, -3000, -3000, 1'b0);
        chkCh(2, 10000, 10000, 10000, 1'b0);
        chk(ratioLed, 64'(1'b0));
        // Offset, ratio and expand per channel
        wr(ADDR_CFG_X, 32'h00003028);
        wr(ADDR_CFG_Y, 32'h000047f6);
        wr(ADDR_CFG_R, 32'h00001000);
        wr(ADDR_MISC, 32'h0000001f);
        aux4 <= 16'sh07d0;
        sample(500, -300, 1000, 18000);
        chkCh(0, 10000, 1000, 1000, 1'b0);
        chkCh(1, -10000, -2000, -2000, 1'b1);
        chkCh(2, 10000, 10000, 20000, 1'b1);
        chk(offInd, 64'(3'b011));
        chk(ratInd, 64'(3'b100));
        chk(expInd, 64'(3'b011));
        chk(ratioLed, 64'(1'b1));
        chk(firstOut, 64'(10000));
        chk(secondOut, 64'(10000));
        chk(phaseReadout, 64'(18000));
        chk(gainCode, 64'(RANGE_10MV));
        rd(ADDR_STAT, 32'h00000006);
        rd(ADDR_RD_X, 32'h000003e8);
        rd(ADDR_RD_Y, 32'hfffff830);
        rd(ADDR_RD_R, 32'h00004e20);
        rd(ADDR_RD_PH, 32'h00004650);
        // Sensitivity change keeps the stored percentage; X now ratioed by aux3
        wr(ADDR_SENS, 32'h000007d0);
        rd(ADDR_CFG_X, 32'h00003028);
        wr(ADDR_MISC, 32'h0000000a);
        aux3 <= 16'sh01f4;
        sample(500, -300, 1000, 27000);
        chkCh(0, -10000, -2750, -2750, 1'b1);
        chkCh(2, 10000, 10000, 10000, 1'b0);
        chk(ratInd, 64'(3'b101));
        chk(phaseReadout, 64'(-9000));
        chk(phaseBar, 64'(-9000));
        chk(secondOut, 64'(-5000));
        chk(firstOut, 64'(-10000));
        chk(gainCode, 64'(3'h2));
        rd(ADDR_RD_X, 32'hfffff542);
        rd(ADDR_RD_PH, 32'hffffdcd8);
        // Offset beyond the limit and the unused expand code
        wr(ADDR_CFG_X, 32'h00000400);
        rd(ADDR_CFG_X, 32'h00000419);
        wr(ADDR_CFG_Y, 32'h00006000);
        rd(ADDR_CFG_Y, 32'h0);
        chk(rangeErr, 64'(1'b0));
        report_and_stop();
    end
endmodule
